/* design/pee_pkg.sv */
package pee_pkg;

  // ------------------------------------------------------------
  // bus addressing
  // ------------------------------------------------------------
  localparam logic [6:0] EE_CTL = 7'h57; // 1010111x, protected block
  localparam logic [6:0] RTC_CTL = 7'h6f; // 1101111x, clock regs and sram
  localparam logic [7:0] EE_LO = 8'hf0;
  localparam logic [7:0] EE_HI = 8'hf7;
  localparam logic [7:0] UNLOCK_ADDR = 8'h0f; // key location in clock space
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;

  // ------------------------------------------------------------
  // reset values and counts
  // ------------------------------------------------------------
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [7:0] EE_BLANK = 8'hff;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam int unsigned NODE_FIRST = 2; // node identifier starts at 0xf2
  localparam logic [47:0] EE_NODE_ID = 48'h0a0b0c_010203; // arbitrary value
  localparam int unsigned EE_WR_CYCLES = 5000; // internal write cycle length
  localparam logic [3:0] CNT_LAST = 4'h7; // eighth data bit
  localparam logic [3:0] CNT_ACK = 4'h8; // acknowledge slot
  localparam logic [3:0] CNT_END = 4'h9; // slot finished

  // ------------------------------------------------------------
  // state encodings
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    PH_IDLE = 5'b00001,
    PH_CTRL = 5'b00010,
    PH_ADDR = 5'b00100,
    PH_DATA = 5'b01000,
    PH_TX   = 5'b10000
  } pee_ph_e;

  typedef enum logic [2:0] {
    LK_LOCKED = 3'b001,
    LK_GOT55  = 3'b010,
    LK_OPEN   = 3'b100
  } pee_lock_e;

endpackage

/* design/pee_access.sv */
// Contract
// - protected block at f0-f7, control 1010111x
// - out-of-range write address: nack, store nothing
// - reads never need the unlock handshake
// - unlock key location unstored, reads zero
// - unlock only after 0x55 then 0xaa
// - broken handshake keeps block locked
// - relock after every write operation
// - byte write acked, stop starts write
// - busy: nack every protected control byte
// - clock and sram served while busy
// - pointer follows last written byte
// - page bytes buffered, committed after stop
// - page write bumps low three bits
// - current read returns last address plus one
// - one pointer shared by both spaces
// - random read sets pointer, then reads
// - master ack requests next byte
// - sequential read wraps f7 to f0
// - node identifier held at f2-f7
// - clock space answers 1101111x
`timescale 1ns/1ps

// ------------------------------------------------------------
// two-stage synchroniser
// ------------------------------------------------------------
module pee_sync2 #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic d,
  output logic q
);
  logic meta_q;

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else if (en) begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // pee_sync2

// ------------------------------------------------------------
// protected block access
// ------------------------------------------------------------
module pee_access #(
  parameter int unsigned WR_CYCLES = pee_pkg::EE_WR_CYCLES,
  parameter logic NODE_ID_EN = 1'b1
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic scl_clk,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  output logic [7:0] rtc_addr,
  output logic [7:0] rtc_wdata,
  output logic rtc_we,
  input wire logic [7:0] rtc_rdata,
  output logic ee_busy,
  output logic ee_unlocked
);
  logic lrst_n, lbit_q, ltog_q, tog_s, scl_s, sda_s, tog_p_q, scl_p_q, sda_p_q;
  logic bit_ev, start_ev, stop_ev, fall_ev, rx_ph, byte_done, is_ee_ctl, is_rtc_ctl;
  logic dec_ack, ack_q, space_ee_q, mack_q, wr_ee_q, busy_q, oe_n_q, we_q, step_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q, byte_w, tx_q, ptr_q, wdata_q;
  logic [7:0] page_q [8];
  logic [7:0] mem_q [8];
  logic [7:0] pv_q;
  logic [7:0] rd_now;
  logic [31:0] wcnt_q;
  pee_pkg::pee_ph_e ph_q, nxt_q, dec_nxt;
  pee_pkg::pee_lock_e lock_q;

  // ------------------------------------------------------------
  // link domain
  // ------------------------------------------------------------
  pee_sync2 #(.RST_VAL(1'b0)) u_lrst (.clk(scl_clk), .rst_n(1'b1), .en(1'b1),
    .d(rst_n), .q(lrst_n));

  // sample sda on each rising scl, announce by toggle
  always_ff @(posedge scl_clk) begin
    if (!lrst_n) begin
      lbit_q <= 1'b1;
      ltog_q <= 1'b0;
    end else begin
      lbit_q <= sda_i;
      ltog_q <= ~ltog_q;
    end
  end

  // ------------------------------------------------------------
  // crossings and bus events
  // ------------------------------------------------------------
  pee_sync2 #(.RST_VAL(1'b0)) u_tog (.clk(sys_clk), .rst_n(rst_n), .en(ce),
    .d(ltog_q), .q(tog_s));
  pee_sync2 #(.RST_VAL(1'b1)) u_scl (.clk(sys_clk), .rst_n(rst_n), .en(ce),
    .d(scl_clk), .q(scl_s));
  pee_sync2 #(.RST_VAL(1'b1)) u_sda (.clk(sys_clk), .rst_n(rst_n), .en(ce),
    .d(sda_i), .q(sda_s));

  // previous synced levels for edge detection
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tog_p_q <= 1'b0;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else if (ce) begin
      tog_p_q <= tog_s;
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // lbit_q is stable for a whole scl period after its toggle
  assign bit_ev = ce && (tog_s ^ tog_p_q);
  assign start_ev = ce && scl_s && scl_p_q && sda_p_q && !sda_s;
  assign stop_ev = ce && scl_s && scl_p_q && !sda_p_q && sda_s;
  assign fall_ev = ce && scl_p_q && !scl_s;
  assign rx_ph = (ph_q == pee_pkg::PH_CTRL) || (ph_q == pee_pkg::PH_ADDR)
    || (ph_q == pee_pkg::PH_DATA);
  assign byte_w = {sh_q[6:0], lbit_q};
  assign byte_done = bit_ev && rx_ph && (cnt_q == pee_pkg::CNT_LAST);
  assign is_ee_ctl = (byte_w[7:1] == pee_pkg::EE_CTL);
  assign is_rtc_ctl = (byte_w[7:1] == pee_pkg::RTC_CTL);

  function automatic logic in_rng(input logic [7:0] a);
    in_rng = (a >= pee_pkg::EE_LO) && (a <= pee_pkg::EE_HI);
  endfunction

  // read byte at the shared pointer, no lock check
  function automatic logic [7:0] rd_byte(input logic ee);
    if (ee) begin
      rd_byte = in_rng(ptr_q) ? mem_q[ptr_q[2:0]] : pee_pkg::ZERO_BYTE;
    end else if (ptr_q == pee_pkg::UNLOCK_ADDR) begin
      rd_byte = pee_pkg::ZERO_BYTE;
    end else begin
      rd_byte = rtc_rdata;
    end
  endfunction

  // next pointer: block wraps on low three bits, clock space plain
  function automatic logic [7:0] ptr_inc(input logic ee);
    if (ee) begin
      ptr_inc = {ptr_q[7:3], ptr_q[2:0] + 3'h1};
    end else begin
      ptr_inc = ptr_q + 8'h01;
    end
  endfunction

  // byte at the pointer, first bit of the next transmit slot
  always_comb begin
    rd_now = rd_byte(space_ee_q);
  end

  // ------------------------------------------------------------
  // acknowledge decision per received byte
  // ------------------------------------------------------------
  always_comb begin
    dec_ack = 1'b0;
    dec_nxt = pee_pkg::PH_IDLE;
    case (ph_q)
      pee_pkg::PH_CTRL: begin
        if ((is_ee_ctl && !busy_q) || is_rtc_ctl) begin
          dec_ack = 1'b1;
          dec_nxt = byte_w[0] ? pee_pkg::PH_TX : pee_pkg::PH_ADDR;
        end
      end
      pee_pkg::PH_ADDR: begin
        if (!space_ee_q || in_rng(byte_w)) begin
          dec_ack = 1'b1;
          dec_nxt = pee_pkg::PH_DATA;
        end
      end
      pee_pkg::PH_DATA: begin
        dec_ack = 1'b1;
        dec_nxt = pee_pkg::PH_DATA;
      end
      default: begin
        dec_ack = 1'b0;
        dec_nxt = pee_pkg::PH_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------
  // protocol sequencing
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ph_q <= pee_pkg::PH_IDLE;
      nxt_q <= pee_pkg::PH_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      ack_q <= 1'b0;
      space_ee_q <= 1'b0;
      mack_q <= 1'b0;
      wr_ee_q <= 1'b0;
    end else if (ce) begin
      if (start_ev) begin
        ph_q <= pee_pkg::PH_CTRL; // repeated start drops an unfinished page
        cnt_q <= 4'h0;
        wr_ee_q <= 1'b0;
      end else if (stop_ev) begin
        ph_q <= pee_pkg::PH_IDLE;
        cnt_q <= 4'h0;
        wr_ee_q <= 1'b0;
      end else if (bit_ev && ph_q != pee_pkg::PH_IDLE) begin
        if (cnt_q != pee_pkg::CNT_END) begin
          cnt_q <= cnt_q + 4'h1;
        end
        if (rx_ph && cnt_q < pee_pkg::CNT_ACK) begin
          sh_q <= byte_w;
        end
        if (byte_done) begin
          ack_q <= dec_ack;
          nxt_q <= dec_nxt;
          if (ph_q == pee_pkg::PH_CTRL) begin
            space_ee_q <= is_ee_ctl;
          end
          if (ph_q == pee_pkg::PH_DATA && space_ee_q) begin
            wr_ee_q <= 1'b1;
          end
        end
        if (ph_q == pee_pkg::PH_TX && cnt_q == pee_pkg::CNT_ACK) begin
          mack_q <= !lbit_q;
        end
      end else if (fall_ev && cnt_q == pee_pkg::CNT_END) begin
        cnt_q <= 4'h0;
        if (rx_ph) begin
          ph_q <= ack_q ? nxt_q : pee_pkg::PH_IDLE;
        end else if (ph_q == pee_pkg::PH_TX) begin
          ph_q <= mack_q ? pee_pkg::PH_TX : pee_pkg::PH_IDLE;
        end
      end
    end
  end

  // sda drive changes only after scl falls or on start and stop, held through the high phase
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      oe_n_q <= 1'b1;
    end else if (ce) begin
      if (start_ev || stop_ev) begin
        oe_n_q <= 1'b1;
      end else if (fall_ev && rx_ph && cnt_q == pee_pkg::CNT_ACK) begin
        oe_n_q <= !ack_q;
      end else if (fall_ev && rx_ph && cnt_q == pee_pkg::CNT_END) begin
        oe_n_q <= (ack_q && nxt_q == pee_pkg::PH_TX) ? tx_q[7] : 1'b1;
      end else if (fall_ev && ph_q == pee_pkg::PH_TX) begin
        if (cnt_q == pee_pkg::CNT_END) begin
          oe_n_q <= mack_q ? rd_now[7] : 1'b1;
        end else if (cnt_q == pee_pkg::CNT_ACK || cnt_q == 4'h0) begin
          oe_n_q <= 1'b1;
        end else begin
          oe_n_q <= tx_q[3'(4'h7 - cnt_q)];
        end
      end
    end
  end

  // transmit byte loads
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tx_q <= 8'h00;
    end else if (ce) begin
      if (byte_done && ph_q == pee_pkg::PH_CTRL) begin
        tx_q <= rd_byte(is_ee_ctl);
      end else if (fall_ev && ph_q == pee_pkg::PH_TX && cnt_q == pee_pkg::CNT_END) begin
        tx_q <= rd_byte(space_ee_q);
      end
    end
  end

  // ------------------------------------------------------------
  // shared address pointer
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ptr_q <= pee_pkg::PTR_RST;
    end else if (ce) begin
      if (byte_done && ph_q == pee_pkg::PH_ADDR && dec_ack) begin
        ptr_q <= byte_w;
      end else if (byte_done && ph_q == pee_pkg::PH_DATA && space_ee_q) begin
        ptr_q <= ptr_inc(1'b1);
      end else if (step_q) begin
        ptr_q <= ptr_inc(1'b0); // clock space steps after its strobe
      end else if (bit_ev && ph_q == pee_pkg::PH_TX && cnt_q == pee_pkg::CNT_ACK) begin
        ptr_q <= ptr_inc(space_ee_q);
      end
    end
  end

  // clock/sram write strobe, key location intercepted
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      we_q <= 1'b0;
      step_q <= 1'b0;
      wdata_q <= 8'h00;
    end else if (ce) begin
      step_q <= byte_done && ph_q == pee_pkg::PH_DATA && !space_ee_q;
      we_q <= byte_done && ph_q == pee_pkg::PH_DATA && !space_ee_q
        && ptr_q != pee_pkg::UNLOCK_ADDR;
      if (byte_done && ph_q == pee_pkg::PH_DATA) begin
        wdata_q <= byte_w;
      end
    end
  end

  // ------------------------------------------------------------
  // unlock handshake
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lock_q <= pee_pkg::LK_LOCKED;
    end else if (ce) begin
      if (stop_ev && wr_ee_q) begin
        lock_q <= pee_pkg::LK_LOCKED;
      end else if (byte_done && ph_q == pee_pkg::PH_DATA && !space_ee_q) begin
        if (ptr_q != pee_pkg::UNLOCK_ADDR) begin
          lock_q <= pee_pkg::LK_LOCKED;
        end else if (lock_q == pee_pkg::LK_LOCKED && byte_w == pee_pkg::KEY_FIRST) begin
          lock_q <= pee_pkg::LK_GOT55;
        end else if (lock_q == pee_pkg::LK_GOT55 && byte_w == pee_pkg::KEY_SECOND) begin
          lock_q <= pee_pkg::LK_OPEN;
        end else begin
          lock_q <= pee_pkg::LK_LOCKED;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // page buffer
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pv_q <= 8'h00;
      for (int i = 0; i < 8; i++) begin
        page_q[i] <= 8'h00;
      end
    end else if (ce) begin
      if (byte_done && ph_q == pee_pkg::PH_ADDR && space_ee_q) begin
        pv_q <= 8'h00;
      end else if (byte_done && ph_q == pee_pkg::PH_DATA && space_ee_q) begin
        page_q[ptr_q[2:0]] <= byte_w;
        pv_q[ptr_q[2:0]] <= 1'b1;
      end else if (busy_q && wcnt_q == 32'h0) begin
        pv_q <= 8'h00;
      end
    end
  end

  // ------------------------------------------------------------
  // internal write cycle and storage
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      wcnt_q <= 32'h0;
      for (int i = 0; i < 8; i++) begin
        mem_q[i] <= (NODE_ID_EN && i >= pee_pkg::NODE_FIRST)
          ? pee_pkg::EE_NODE_ID[8*(7-i) +: 8] : pee_pkg::EE_BLANK;
      end
    end else if (ce) begin
      if (stop_ev && wr_ee_q && lock_q == pee_pkg::LK_OPEN && !busy_q) begin
        busy_q <= 1'b1;
        wcnt_q <= WR_CYCLES - 32'h1;
      end else if (busy_q) begin
        if (wcnt_q == 32'h0) begin
          busy_q <= 1'b0;
          for (int i = 0; i < 8; i++) begin
            if (pv_q[i]) begin
              mem_q[i] <= page_q[i];
            end
          end
        end else begin
          wcnt_q <= wcnt_q - 32'h1;
        end
      end
    end
  end

  // outputs straight from flops, sda_o tied low
  assign sda_o = 1'b0;
  assign sda_oe_n = oe_n_q;
  assign rtc_addr = ptr_q;
  assign rtc_wdata = wdata_q;
  assign rtc_we = we_q;
  assign ee_busy = busy_q;
  assign ee_unlocked = lock_q[2];

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_first_key;
    byte_done && ph_q == pee_pkg::PH_DATA && !space_ee_q
      && ptr_q == pee_pkg::UNLOCK_ADDR && byte_w == pee_pkg::KEY_FIRST;
  endsequence

  property p_ctl_pattern;
    byte_done && ph_q == pee_pkg::PH_CTRL && !is_ee_ctl && !is_rtc_ctl |=> !ack_q;
  endproperty
  a_ctl_pattern: assert property (p_ctl_pattern) else $error("foreign control acked");

  property p_range_nack;
    byte_done && ph_q == pee_pkg::PH_ADDR && space_ee_q && !in_rng(byte_w)
      |=> !ack_q && ptr_q == $past(ptr_q);
  endproperty
  a_range_nack: assert property (p_range_nack) else $error("out of range acked");

  property p_busy_nack;
    byte_done && ph_q == pee_pkg::PH_CTRL && is_ee_ctl && busy_q |=> !ack_q;
  endproperty
  a_busy_nack: assert property (p_busy_nack) else $error("acked while busy");

  property p_rtc_served;
    byte_done && ph_q == pee_pkg::PH_CTRL && is_rtc_ctl |=> ack_q;
  endproperty
  a_rtc_served: assert property (p_rtc_served) else $error("clock space refused");

  property p_page_step;
    byte_done && ph_q == pee_pkg::PH_DATA && space_ee_q
      |=> ptr_q[7:3] == $past(ptr_q[7:3]) && ptr_q[2:0] == $past(ptr_q[2:0]) + 3'h1;
  endproperty
  a_page_step: assert property (p_page_step) else $error("page pointer step wrong");

  property p_read_wrap;
    bit_ev && ph_q == pee_pkg::PH_TX && cnt_q == pee_pkg::CNT_ACK && space_ee_q
      && ptr_q == pee_pkg::EE_HI |=> ptr_q == pee_pkg::EE_LO;
  endproperty
  a_read_wrap: assert property (p_read_wrap) else $error("read did not wrap");

  property p_key_zero;
    byte_done && ph_q == pee_pkg::PH_CTRL && is_rtc_ctl && byte_w[0]
      && ptr_q == pee_pkg::UNLOCK_ADDR |=> tx_q == pee_pkg::ZERO_BYTE;
  endproperty
  a_key_zero: assert property (p_key_zero) else $error("key location not zero");

  property p_unlock_order;
    $rose(lock_q == pee_pkg::LK_OPEN) |-> $past(lock_q == pee_pkg::LK_GOT55);
  endproperty
  a_unlock_order: assert property (p_unlock_order) else $error("unlock out of order");

  property p_first_key;
    s_first_key ##0 lock_q == pee_pkg::LK_LOCKED |=> lock_q == pee_pkg::LK_GOT55;
  endproperty
  a_first_key: assert property (p_first_key) else $error("first key lost");

  property p_relock;
    stop_ev && wr_ee_q |=> lock_q == pee_pkg::LK_LOCKED;
  endproperty
  a_relock: assert property (p_relock) else $error("not relocked");

  property p_busy_hold;
    busy_q && wcnt_q != 32'h0 && ce |=> busy_q && wcnt_q == $past(wcnt_q) - 32'h1;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy ended early");

endmodule // pee_access

/* dv/pee_bus_master.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------
// two-wire bus master model
// ------------------------------------------------------------
module pee_bus_master (
  input wire logic sda_wire,
  output logic scl,
  output logic sda_low
);
  // idle bus: clock stands high, data released to pull-up
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // clock pulses with data high, to move the link reset in and out
  task automatic idle_clocks(input int n);
    repeat (n) begin
      scl = 1'b0;
      #32;
      scl = 1'b1;
      #32;
    end
  endtask

  // start or repeated start, data falls while clock high
  task automatic start();
    #16;
    sda_low = 1'b0;
    #16;
    scl = 1'b1;
    #32;
    sda_low = 1'b1;
    #32;
    scl = 1'b0;
    #16;
  endtask

  // stop, data rises while clock high; also ends a timed-out poll
  task automatic stop();
    sda_low = 1'b1;
    #16;
    scl = 1'b1;
    #32;
    sda_low = 1'b0;
    #32;
  endtask

  // one bit set mid low phase, held through the high phase
  task automatic put_bit(input logic b);
    sda_low = ~b;
    #16;
    scl = 1'b1;
    #32;
    scl = 1'b0;
    #16;
  endtask

  // byte out msb first, then sample the device acknowledge
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) put_bit(b[i]);
    sda_low = 1'b0;
    #16;
    scl = 1'b1;
    #16;
    ack = (sda_wire === 1'b0);
    #16;
    scl = 1'b0;
    #16;
  endtask

  // byte in; ack asks for the next byte, nack ends the read
  task automatic get_byte(input logic more, output logic [7:0] b);
    sda_low = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      #16;
      scl = 1'b1;
      #16;
      b[i] = sda_wire;
      #16;
      scl = 1'b0;
      #16;
    end
    put_bit(~more);
  endtask
endmodule // pee_bus_master

/* dv/testbench.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------
// bench top
// ------------------------------------------------------------
module testbench;
  localparam int unsigned WR = 1000;
  logic sys_clk, rst_n, ce, scl_clk, sda_low, sda_wire, sda_o, sda_oe_n;
  logic rtc_we, ee_busy, ee_unlocked, a;
  logic [7:0] rtc_addr, rtc_wdata, rtc_rdata, q, acks;
  logic [7:0] sram [256];
  logic [7:0] rdq [8];
  int err_count, compares, n, k;

  // open-drain wire with pull-up
  assign sda_wire = sda_low ? 1'b0 : (sda_oe_n ? 1'b1 : sda_o);
  assign rtc_rdata = sram[rtc_addr];

  // clock-space memory behind the shared pointer
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 256; i++) sram[i] <= 8'h00;
    end else if (rtc_we) begin
      sram[rtc_addr] <= rtc_wdata;
    end
  end

  pee_access #(.WR_CYCLES(WR), .NODE_ID_EN(1'b1)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .ce(ce), .scl_clk(scl_clk), .sda_i(sda_wire), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .rtc_addr(rtc_addr), .rtc_wdata(rtc_wdata), .rtc_we(rtc_we), .rtc_rdata(rtc_rdata),
    .ee_busy(ee_busy), .ee_unlocked(ee_unlocked));
  pee_bus_master m (.sda_wire(sda_wire), .scl(scl_clk), .sda_low(sda_low));

  // system clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      $display("mismatch %s exp %h seen %h", what, exp, seen);
      err_count++;
    end
  endtask

  task automatic conclude();
    if (err_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // control, address, one data byte, stop; acks in bits 2..0
  task automatic wr_cmd(input logic [7:0] ctl, input logic [7:0] adr, input logic [7:0] dat);
    acks = 8'h00;
    m.start();
    m.put_byte(ctl, acks[2]);
    m.put_byte(adr, acks[1]);
    m.put_byte(dat, acks[0]);
    m.stop();
  endtask

  // random read of cnt bytes into rdq, last one nacked
  task automatic rd_seq(input logic [7:0] ctl, input logic [7:0] adr, input int cnt);
    m.start();
    m.put_byte(ctl, a);
    m.put_byte(adr, a);
    m.start();
    m.put_byte(ctl | 8'h01, a);
    for (int i = 0; i < cnt; i++) m.get_byte(i < cnt - 1, rdq[i]);
    m.stop();
  endtask

  // bounded acknowledge polling with the write control byte
  task automatic poll();
    n = 0;
    a = 1'b0;
    while (!a && n < 40) begin
      m.start();
      m.put_byte(8'hae, a);
      m.stop();
      if (!a) n++;
    end
    check("poll ack", {7'h00, a}, 8'h01);
  endtask

  task automatic unlock();
    wr_cmd(8'hde, pee_pkg::UNLOCK_ADDR, pee_pkg::KEY_FIRST);
    wr_cmd(8'hde, pee_pkg::UNLOCK_ADDR, pee_pkg::KEY_SECOND);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    check("busy", {7'h00, ee_busy}, 8'h00);
    check("unlocked", {7'h00, ee_unlocked}, 8'h00);
    check("ptr", rtc_addr, 8'h00);
    check("oe_n", {7'h00, sda_oe_n}, 8'h01);
  endtask

  // node bytes, wrap past the top, then a current read
  task automatic t_read();
    rd_seq(8'hae, 8'hf2, 7);
    for (int i = 0; i < 6; i++) check("node", rdq[i], pee_pkg::EE_NODE_ID[47 - 8 * i -: 8]);
    check("wrap", rdq[6], pee_pkg::EE_BLANK);
    check("ptr", rtc_addr, 8'hf1);
    m.start();
    m.put_byte(8'haf, a);
    check("cur ack", {7'h00, a}, 8'h01);
    m.get_byte(1'b0, q);
    m.stop();
    check("cur", q, pee_pkg::EE_BLANK);
    check("ptr", rtc_addr, 8'hf2);
  endtask

  // foreign control byte, key location read
  task automatic t_space();
    m.start();
    m.put_byte(8'ha0, a);
    m.stop();
    check("bad ctl", {7'h00, a}, 8'h00);
    rd_seq(8'hde, pee_pkg::UNLOCK_ADDR, 1);
    check("key read", rdq[0], 8'h00);
  endtask

  // nine bytes from f6, busy window, clock space meanwhile
  task automatic t_page();
    unlock();
    check("unlocked", {7'h00, ee_unlocked}, 8'h01);
    check("key unstored", sram[8'h0f], 8'h00);
    m.start();
    m.put_byte(8'hae, a);
    m.put_byte(8'hf6, a);
    for (int i = 1; i <= 9; i++) begin
      m.put_byte(8'(i * 17), a);
      check("page ack", {7'h00, a}, 8'h01);
    end
    m.stop();
    repeat (8) @(negedge sys_clk);
    check("busy", {7'h00, ee_busy}, 8'h01);
    check("relock", {7'h00, ee_unlocked}, 8'h00);
    check("ptr", rtc_addr, 8'hf7);
    // frozen enable must stop the write-cycle count
    @(negedge sys_clk);
    ce = 1'b0;
    repeat (1200) @(negedge sys_clk);
    check("frozen busy", {7'h00, ee_busy}, 8'h01);
    ce = 1'b1;
    m.start();
    m.put_byte(8'hae, a);
    m.stop();
    check("busy ack", {7'h00, a}, 8'h00);
    wr_cmd(8'hde, 8'h20, 8'h5a);
    check("rtc acks", acks, 8'h07);
    check("sram", sram[8'h20], 8'h5a);
    check("ptr", rtc_addr, 8'h21);
    poll();
    rd_seq(8'hae, 8'hf0, 8);
    for (int s = 0; s < 8; s++) begin
      k = (s + 3) % 8;
      if (k < 2) k += 8;
      check("page", rdq[s], 8'(k * 17));
    end
  endtask

  // broken handshake, then an out-of-range write
  task automatic t_locked();
    wr_cmd(8'hde, pee_pkg::UNLOCK_ADDR, pee_pkg::KEY_FIRST);
    wr_cmd(8'hde, pee_pkg::UNLOCK_ADDR, 8'h12);
    check("unlocked", {7'h00, ee_unlocked}, 8'h00);
    wr_cmd(8'hae, 8'hf0, 8'h77);
    poll();
    rd_seq(8'hae, 8'hf0, 1);
    check("locked", rdq[0], 8'h33);
    m.start();
    m.put_byte(8'hae, a);
    m.put_byte(8'h10, a);
    check("addr nack", {7'h00, a}, 8'h00);
    m.put_byte(8'h5a, a);
    check("data nack", {7'h00, a}, 8'h00);
    m.stop();
    check("ptr", rtc_addr, 8'hf1);
    m.start();
    m.put_byte(8'haf, a);
    check("ready", {7'h00, a}, 8'h01);
    m.get_byte(1'b0, q);
    m.stop();
  endtask

  // main sequence
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    err_count = 0;
    compares = 0;
    m.idle_clocks(4);
    @(negedge sys_clk);
    rst_n = 1'b1;
    m.idle_clocks(3); // link reset leaves only on scl edges
    repeat (4) @(negedge sys_clk);
    t_reset();
    t_read();
    t_space();
    t_page();
    t_locked();
    conclude();
  end

  // watchdog against a hung bus
  initial begin
    #400000;
    err_count++;
    conclude();
  end
endmodule // testbench
